// file: src/xfer_params.svh
`ifndef XFER_PARAMS_SVH
`define XFER_PARAMS_SVH

`define NIB_W       4
`define ADDR_W      8
`define SEL_W       3
`define IDX_W       4
`define MEM_DEPTH   256
`define REG_CNT     16

`define IDX_A       4'h0
`define IDX_X       4'h1
`define IDX_L       4'h2
`define IDX_H       4'h3
`define IDX_E       4'h4
`define IDX_D       4'h5

`define REG_CODE_A  3'h0
`define PAIR_CODE_XA 3'h0

`define NIB_ZERO    4'h0
`define NIB_ONE     4'h1
`define NIB_ONES    4'hf

`endif

// file: src/xfer_pkg.sv
package xfer_pkg;

    typedef enum logic [4:0] {
        op_nop             = 5'h00,
        op_ld_acc_imm      = 5'h01,
        op_ld_reg_imm      = 5'h02,
        op_ld_accpair_imm  = 5'h03,
        op_ld_dpp_imm      = 5'h04,
        op_ld_pair_imm     = 5'h05,
        op_ld_acc_ind      = 5'h06,
        op_ld_accpair_ind  = 5'h07,
        op_st_acc_ind      = 5'h08,
        op_st_accpair_ind  = 5'h09,
        op_ld_acc_dir      = 5'h0a,
        op_ld_accpair_dir  = 5'h0b,
        op_st_acc_dir      = 5'h0c,
        op_st_accpair_dir  = 5'h0d,
        op_ld_acc_reg      = 5'h0e,
        op_ld_accpair_pair = 5'h0f,
        op_st_reg_acc      = 5'h10,
        op_st_pair_accpair = 5'h11,
        op_sw_acc_ind      = 5'h12,
        op_sw_accpair_ind  = 5'h13,
        op_sw_acc_dir      = 5'h14,
        op_sw_accpair_dir  = 5'h15,
        op_sw_acc_reg      = 5'h16,
        op_sw_accpair_pair = 5'h17
    } op_type;

    typedef enum logic [2:0] {
        ptr_hl     = 3'h0,
        ptr_hl_inc = 3'h1,
        ptr_hl_dec = 3'h2,
        ptr_de     = 3'h3,
        ptr_dl     = 3'h4
    } ptr_sel_type;

    typedef enum logic [1:0] {
        str_none = 2'b00,
        str_acc  = 2'b01,
        str_ptr  = 2'b11
    } str_run_type;

endpackage : xfer_pkg

// file: src/xfer_ptr_unit.sv
`timescale 1ns/1ps
`include "xfer_params.svh"

module xfer_ptr_unit (
    input  wire xfer_pkg::ptr_sel_type ptr_sel_i,
    input  wire logic [`NIB_W-1:0]     h_i,
    input  wire logic [`NIB_W-1:0]     l_i,
    input  wire logic [`NIB_W-1:0]     d_i,
    input  wire logic [`NIB_W-1:0]     e_i,
    output logic [`ADDR_W-1:0]         addr_o,
    output logic [`NIB_W-1:0]          nxt_l_o,
    output logic                       l_upd_o,
    output logic                       skip_o
);
    import xfer_pkg::*;

    always_comb begin
        addr_o  = {h_i, l_i};
        nxt_l_o = l_i;
        l_upd_o = 1'b0;
        skip_o  = 1'b0;
        unique case (ptr_sel_i)
            ptr_hl: begin
                addr_o = {h_i, l_i};
            end
            ptr_hl_inc: begin
                nxt_l_o = 4'(l_i + `NIB_ONE);
                l_upd_o = 1'b1;
                skip_o  = (4'(l_i + `NIB_ONE) == `NIB_ZERO);
            end
            ptr_hl_dec: begin
                nxt_l_o = 4'(l_i - `NIB_ONE);
                l_upd_o = 1'b1;
                skip_o  = (4'(l_i - `NIB_ONE) == `NIB_ONES);
            end
            ptr_de: begin
                addr_o = {d_i, e_i};
            end
            ptr_dl: begin
                addr_o = {d_i, l_i};
            end
            default: begin
                addr_o = {h_i, l_i};
            end
        endcase
    end

endmodule : xfer_ptr_unit

// file: src/xfer_exec.sv
`timescale 1ns/1ps
`include "xfer_params.svh"

// Notes on behaviour
// - Nibble immediate loads accumulator only.
// - Immediate accumulator loads after nibble load become no-ops.
// - Byte load to pair; following immediate accumulator loads squashed.
// - Pointer byte load; only repeats squashed.
// - Post-increment low pointer; skip on zero.
// - Post-decrement low pointer; skip on all ones.
// - Five pointer selections for indirect accumulator load and swap.
// - Pair read: even address low, next high.
// - Pair write: even address low, next high.
// - Direct nibble read over full address range.
// - Direct pair access uses even addresses only.
// - Direct write stores accumulator, pair adds upper.
// - Any of eight registers into accumulator.
// - Any of eight pairs into accumulator pair.
// - Accumulator into seven registers, not itself.
// - Accumulator pair into seven other pairs.
// - Indirect swap of accumulator with memory.
// - Pointer adjusted after swap, skip on result.
// - Pair swap with even-aligned memory nibbles.
// - Direct swap of accumulator with memory.
// - Swap accumulator pair or register with others.

module xfer_exec (
    input  wire logic                 core_clk_i,
    input  wire logic                 reset_i,
    input  wire logic                 instr_valid_i,
    input  wire xfer_pkg::op_type     op_i,
    input  wire logic [`SEL_W-1:0]    sel_i,
    input  wire logic [`ADDR_W-1:0]   imm_i,
    input  wire logic [`ADDR_W-1:0]   dbg_addr_i,
    input  wire logic [`IDX_W-1:0]    reg_sel_i,
    output logic [`NIB_W-1:0]         acc_o,
    output logic [`NIB_W-1:0]         upper_acc_o,
    output logic [`ADDR_W-1:0]        ptr_o,
    output logic                      skip_pending_o,
    output logic                      squashed_o,
    output logic [`NIB_W-1:0]         dbg_data_o,
    output logic [`NIB_W-1:0]         reg_data_o
);
    import xfer_pkg::*;

    function automatic logic [`IDX_W-1:0] pair_lo(
        input logic [`SEL_W-1:0] code
    );
        return {code[0], code[2:1], 1'b0};
    endfunction : pair_lo

    function automatic logic [`IDX_W-1:0] pair_hi(
        input logic [`SEL_W-1:0] code
    );
        return {code[0], code[2:1], 1'b1};
    endfunction : pair_hi

    logic [`NIB_W-1:0]   regs_ff      [`REG_CNT];
    logic [`NIB_W-1:0]   nxt_regs     [`REG_CNT];
    logic [`NIB_W-1:0]   mem          [`MEM_DEPTH];
    logic                skip_ff;
    logic                nxt_skip;
    logic                squash_ff;
    logic                nxt_squash;
    str_run_type         str_run_ff;
    str_run_type         nxt_str_run;
    logic [`NIB_W-1:0]   dbg_ff;
    logic [`NIB_W-1:0]   reg_peek_ff;

    logic                wr0_en;
    logic                wr1_en;
    logic [`NIB_W-1:0]   wr0_data;
    logic [`NIB_W-1:0]   wr1_data;
    logic                ptr_mode;
    logic                ind_op;
    logic                pair_op;
    logic                suppress;
    logic                executed;
    ptr_sel_type         ptr_sel;
    logic [`ADDR_W-1:0]  ptr_addr;
    logic [`NIB_W-1:0]   ptr_nxt_l;
    logic                ptr_upd;
    logic                ptr_skip;
    logic [`ADDR_W-1:0]  base_addr;
    logic [`ADDR_W-1:0]  addr0;
    logic [`ADDR_W-1:0]  addr1;
    logic [`NIB_W-1:0]   rd0;
    logic [`NIB_W-1:0]   rd1;
    logic [`IDX_W-1:0]   reg_idx;
    logic [`NIB_W-1:0]   reg_src;

    assign ptr_mode = (op_i == op_ld_acc_ind) || (op_i == op_sw_acc_ind);
    assign ind_op   = ptr_mode || (op_i == op_ld_accpair_ind)
                   || (op_i == op_st_acc_ind) || (op_i == op_st_accpair_ind)
                   || (op_i == op_sw_accpair_ind);
    assign pair_op  = (op_i == op_ld_accpair_ind)
                   || (op_i == op_st_accpair_ind)
                   || (op_i == op_sw_accpair_ind)
                   || (op_i == op_ld_accpair_dir)
                   || (op_i == op_st_accpair_dir)
                   || (op_i == op_sw_accpair_dir);
    // Only the single-nibble accumulator load and swap forms honour the pointer field.
    assign ptr_sel  = ptr_mode ? ptr_sel_type'(sel_i) : ptr_hl;

    xfer_ptr_unit u_ptr (
        .ptr_sel_i (ptr_sel),
        .h_i       (regs_ff[`IDX_H]),
        .l_i       (regs_ff[`IDX_L]),
        .d_i       (regs_ff[`IDX_D]),
        .e_i       (regs_ff[`IDX_E]),
        .addr_o    (ptr_addr),
        .nxt_l_o   (ptr_nxt_l),
        .l_upd_o   (ptr_upd),
        .skip_o    (ptr_skip)
    );

    assign base_addr = ind_op ? ptr_addr : imm_i;
    // The low address bit is dropped for pairs, so an odd pointer or an odd
    // direct field still lands on the aligned pair.
    assign addr0 = pair_op ? {base_addr[7:1], 1'b0} : base_addr;
    assign addr1 = {base_addr[7:1], 1'b1};
    assign rd0   = mem[addr0];
    assign rd1   = mem[addr1];

    assign reg_idx = {1'b0, sel_i};
    assign reg_src = regs_ff[reg_idx];

    assign suppress = ((str_run_ff == str_acc)
                       && ((op_i == op_ld_acc_imm)
                           || (op_i == op_ld_accpair_imm)))
                   || ((str_run_ff == str_ptr)
                       && (op_i == op_ld_dpp_imm));
    assign executed = instr_valid_i && !skip_ff && !suppress;

    always_comb begin
        nxt_regs    = regs_ff;
        nxt_skip    = skip_ff;
        nxt_squash  = 1'b0;
        nxt_str_run = str_run_ff;
        wr0_en      = 1'b0;
        wr1_en      = 1'b0;
        wr0_data    = regs_ff[`IDX_A];
        wr1_data    = regs_ff[`IDX_X];
        if (instr_valid_i) begin
            nxt_str_run = str_none;
            if (skip_ff) begin
                // The discarded instruction leaves registers and memory alone but ends any load run.
                nxt_skip   = 1'b0;
                nxt_squash = 1'b1;
            end else if (suppress) begin
                nxt_squash  = 1'b1;
                nxt_str_run = str_run_ff;
            end else begin
                unique case (op_i)
                    op_nop: begin
                        nxt_skip = 1'b0;
                    end
                    op_ld_acc_imm: begin
                        nxt_regs[`IDX_A] = imm_i[3:0];
                        nxt_str_run      = str_acc;
                    end
                    op_ld_reg_imm: begin
                        if (sel_i != `REG_CODE_A) begin
                            nxt_regs[reg_idx] = imm_i[3:0];
                        end
                    end
                    op_ld_accpair_imm: begin
                        nxt_regs[`IDX_A] = imm_i[3:0];
                        nxt_regs[`IDX_X] = imm_i[7:4];
                        nxt_str_run      = str_acc;
                    end
                    op_ld_dpp_imm: begin
                        nxt_regs[`IDX_L] = imm_i[3:0];
                        nxt_regs[`IDX_H] = imm_i[7:4];
                        nxt_str_run      = str_ptr;
                    end
                    op_ld_pair_imm: begin
                        nxt_regs[pair_lo(sel_i)] = imm_i[3:0];
                        nxt_regs[pair_hi(sel_i)] = imm_i[7:4];
                    end
                    op_ld_acc_ind, op_ld_acc_dir: begin
                        nxt_regs[`IDX_A] = rd0;
                    end
                    op_ld_accpair_ind, op_ld_accpair_dir: begin
                        nxt_regs[`IDX_A] = rd0;
                        nxt_regs[`IDX_X] = rd1;
                    end
                    op_st_acc_ind, op_st_acc_dir: begin
                        wr0_en = 1'b1;
                    end
                    op_st_accpair_ind, op_st_accpair_dir: begin
                        wr0_en = 1'b1;
                        wr1_en = 1'b1;
                    end
                    op_ld_acc_reg: begin
                        nxt_regs[`IDX_A] = reg_src;
                    end
                    op_ld_accpair_pair: begin
                        nxt_regs[`IDX_A] = regs_ff[pair_lo(sel_i)];
                        nxt_regs[`IDX_X] = regs_ff[pair_hi(sel_i)];
                    end
                    op_st_reg_acc: begin
                        if (sel_i != `REG_CODE_A) begin
                            nxt_regs[reg_idx] = regs_ff[`IDX_A];
                        end
                    end
                    op_st_pair_accpair: begin
                        if (sel_i != `PAIR_CODE_XA) begin
                            nxt_regs[pair_lo(sel_i)] = regs_ff[`IDX_A];
                            nxt_regs[pair_hi(sel_i)] = regs_ff[`IDX_X];
                        end
                    end
                    op_sw_acc_ind, op_sw_acc_dir: begin
                        nxt_regs[`IDX_A] = rd0;
                        wr0_en           = 1'b1;
                    end
                    op_sw_accpair_ind, op_sw_accpair_dir: begin
                        nxt_regs[`IDX_A] = rd0;
                        nxt_regs[`IDX_X] = rd1;
                        wr0_en           = 1'b1;
                        wr1_en           = 1'b1;
                    end
                    op_sw_acc_reg: begin
                        if (sel_i != `REG_CODE_A) begin
                            nxt_regs[`IDX_A]  = reg_src;
                            nxt_regs[reg_idx] = regs_ff[`IDX_A];
                        end
                    end
                    op_sw_accpair_pair: begin
                        nxt_regs[`IDX_A] = regs_ff[pair_lo(sel_i)];
                        nxt_regs[`IDX_X] = regs_ff[pair_hi(sel_i)];
                        nxt_regs[pair_lo(sel_i)] = regs_ff[`IDX_A];
                        nxt_regs[pair_hi(sel_i)] = regs_ff[`IDX_X];
                    end
                    default: begin
                        nxt_skip = 1'b0;
                    end
                endcase
                // The pointer moves after the access, so the swap and the
                // read both use the old address; the skip sees the new L.
                if (ptr_mode && ptr_upd) begin
                    nxt_regs[`IDX_L] = ptr_nxt_l;
                    nxt_skip         = ptr_skip;
                end
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            for (int i = 0; i < `REG_CNT; i++) begin
                regs_ff[i] <= `NIB_ZERO;
            end
            skip_ff     <= 1'b0;
            squash_ff   <= 1'b0;
            str_run_ff  <= str_none;
            dbg_ff      <= `NIB_ZERO;
            reg_peek_ff <= `NIB_ZERO;
        end else begin
            regs_ff     <= nxt_regs;
            skip_ff     <= nxt_skip;
            squash_ff   <= nxt_squash;
            str_run_ff  <= nxt_str_run;
            dbg_ff      <= mem[dbg_addr_i];
            reg_peek_ff <= regs_ff[reg_sel_i];
        end
    end

    // Data memory keeps its contents through reset; write before reading.
    always_ff @(posedge core_clk_i) begin
        if (wr0_en) begin
            mem[addr0] <= wr0_data;
        end
        if (wr1_en) begin
            mem[addr1] <= wr1_data;
        end
    end

    assign acc_o          = regs_ff[`IDX_A];
    assign upper_acc_o    = regs_ff[`IDX_X];
    assign ptr_o          = {regs_ff[`IDX_H], regs_ff[`IDX_L]};
    assign skip_pending_o = skip_ff;
    assign squashed_o     = squash_ff;
    assign dbg_data_o     = dbg_ff;
    assign reg_data_o     = reg_peek_ff;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    a_imm_nibble_acc: assert property (
        executed && (op_i == op_ld_acc_imm) |=>
        (acc_o == $past(imm_i[3:0])) && (upper_acc_o == $past(upper_acc_o))
        && (ptr_o == $past(ptr_o)))
        else $error("nibble immediate load went wrong");

    a_acc_run_nop: assert property (
        executed && (op_i == op_ld_acc_imm) ##1
        instr_valid_i && (op_i == op_ld_accpair_imm) |=>
        (acc_o == $past(acc_o)) && (upper_acc_o == $past(upper_acc_o))
        && squashed_o)
        else $error("load after nibble load was not squashed");

    a_pair_imm_load: assert property (
        executed && (op_i == op_ld_accpair_imm) |=>
        ({upper_acc_o, acc_o} == $past(imm_i)))
        else $error("byte immediate load to pair went wrong");

    a_ptr_run_nop: assert property (
        instr_valid_i && !skip_ff && (str_run_ff == str_ptr)
        && (op_i == op_ld_dpp_imm) |=> (ptr_o == $past(ptr_o)) && squashed_o)
        else $error("repeated pointer load was not squashed");

    a_inc_wrap_skip: assert property (
        executed && ptr_mode && (sel_i == ptr_hl_inc) |=>
        (ptr_o[3:0] == 4'($past(ptr_o[3:0]) + `NIB_ONE))
        && (skip_pending_o == (ptr_o[3:0] == `NIB_ZERO)))
        else $error("post-increment or its skip went wrong");

    a_dec_wrap_skip: assert property (
        executed && ptr_mode && (sel_i == ptr_hl_dec) |=>
        (ptr_o[3:0] == 4'($past(ptr_o[3:0]) - `NIB_ONE))
        && (skip_pending_o == (ptr_o[3:0] == `NIB_ONES)))
        else $error("post-decrement or its skip went wrong");

    a_skip_discards: assert property (
        instr_valid_i && skip_ff |=>
        (acc_o == $past(acc_o)) && (upper_acc_o == $past(upper_acc_o))
        && (ptr_o == $past(ptr_o)) && !skip_pending_o && squashed_o)
        else $error("skipped instruction changed state");

    a_reg_to_acc: assert property (
        executed && (op_i == op_ld_acc_reg) |=> (acc_o == $past(reg_src)))
        else $error("register to accumulator copy went wrong");

    a_swap_acc_mem: assert property (
        executed && (op_i == op_sw_acc_ind) |=> (acc_o == $past(rd0)))
        else $error("indirect swap did not load memory nibble");

    c_wrap_skip: cover property (
        executed && ptr_mode && ptr_skip ##1 instr_valid_i && skip_ff);
    c_acc_run: cover property (
        executed && (op_i == op_ld_acc_imm) ##1 instr_valid_i && suppress);
    c_pair_swap: cover property (
        executed && (op_i == op_sw_accpair_ind));

endmodule : xfer_exec

// file: test/tb.sv
`timescale 1ns/1ps

module tb;
    import xfer_pkg::*;

    typedef struct packed {
        logic [7:0] ax;
        logic [7:0] p;
        logic [1:0] f;
    } exp_type;

    logic        core_clk_i;
    logic        reset_i;
    logic        instr_valid_i;
    op_type      op_i;
    logic [2:0]  sel_i;
    logic [7:0]  imm_i;
    logic [7:0]  dbg_addr_i;
    logic [3:0]  reg_sel_i;
    logic [3:0]  acc_o;
    logic [3:0]  upper_acc_o;
    logic [7:0]  ptr_o;
    logic        skip_pending_o;
    logic        squashed_o;
    logic [3:0]  dbg_data_o;
    logic [3:0]  reg_data_o;
    logic        taken_ff;
    logic        peek_ff;
    logic        peek_on;
    logic        sk_m;
    str_run_type run_m;
    logic [3:0]  rm [16];
    logic [3:0]  mm [256];
    logic [15:0] rnd;
    exp_type     eq [$];
    logic [8:0]  pq [$];
    int          miscompares;
    int          checked;
    int          cycles;
    op_type      op_k [10];
    op_type      ro;

    xfer_exec i_xfer_exec (
        .core_clk_i     (core_clk_i),
        .reset_i        (reset_i),
        .instr_valid_i  (instr_valid_i),
        .op_i           (op_i),
        .sel_i          (sel_i),
        .imm_i          (imm_i),
        .dbg_addr_i     (dbg_addr_i),
        .reg_sel_i      (reg_sel_i),
        .acc_o          (acc_o),
        .upper_acc_o    (upper_acc_o),
        .ptr_o          (ptr_o),
        .skip_pending_o (skip_pending_o),
        .squashed_o     (squashed_o),
        .dbg_data_o     (dbg_data_o),
        .reg_data_o     (reg_data_o)
    );

    always #5 core_clk_i = ~core_clk_i;

    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr_next

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic end_of_test();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test

    // The ceiling is several times the expected length of the run.
    always @(posedge core_clk_i) begin
        taken_ff <= instr_valid_i && !reset_i;
        peek_ff <= peek_on;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            end_of_test();
        end
    end

    always @(negedge core_clk_i) begin
        exp_type    e;
        logic [8:0] pv;
        logic [3:0] m;
        if (taken_ff && eq.size() > 0) begin
            e = eq.pop_front();
            chk({acc_o, upper_acc_o}, e.ax);
            chk(ptr_o, e.p);
            chk(8'({skip_pending_o, squashed_o}), 8'(e.f));
        end
        if (peek_ff && pq.size() > 0) begin
            pv = pq.pop_front();
            m = pv[8] ? dbg_data_o : pv[7:4];
            chk({m, reg_data_o}, pv[7:0]);
        end
    end

    // Reference state is updated as the instruction is presented, so the
    // noted value already holds what the next edge should produce.
    task automatic model(input op_type op, input logic [2:0] s,
                         input logic [7:0] im);
        logic [7:0] a;
        logic [7:0] e0;
        logic [7:0] e1;
        logic [7:0] t;
        logic       sq;
        int         p;
        sq = 1'b0;
        p = {s[0], s[2:1], 1'b0};
        a = {rm[3], rm[2]};
        if (op inside {op_ld_acc_ind, op_sw_acc_ind} && s == 3'h3)
            a = {rm[5], rm[4]};
        if (op inside {op_ld_acc_ind, op_sw_acc_ind} && s == 3'h4)
            a = {rm[5], rm[2]};
        if (op inside {op_ld_acc_dir, op_ld_accpair_dir, op_st_acc_dir,
                       op_st_accpair_dir, op_sw_acc_dir, op_sw_accpair_dir})
            a = im;
        e0 = {a[7:1], 1'b0};
        e1 = {a[7:1], 1'b1};
        if (sk_m) begin
            sq = 1'b1;
            sk_m = 1'b0;
            run_m = str_none;
        end else if (run_m == str_acc &&
                     op inside {op_ld_acc_imm, op_ld_accpair_imm}) begin
            sq = 1'b1;
        end else if (run_m == str_ptr && op == op_ld_dpp_imm) begin
            sq = 1'b1;
        end else begin
            case (op)
                op_ld_acc_imm:      rm[0] = im[3:0];
                op_ld_reg_imm:      if (s != 3'h0) rm[s] = im[3:0];
                op_ld_accpair_imm:  {rm[1], rm[0]} = im;
                op_ld_dpp_imm:      {rm[3], rm[2]} = im;
                op_ld_pair_imm:     {rm[p+1], rm[p]} = im;
                op_ld_acc_ind, op_ld_acc_dir: rm[0] = mm[a];
                op_ld_accpair_ind, op_ld_accpair_dir:
                    {rm[1], rm[0]} = {mm[e1], mm[e0]};
                op_st_acc_ind, op_st_acc_dir: mm[a] = rm[0];
                op_st_accpair_ind, op_st_accpair_dir:
                    {mm[e1], mm[e0]} = {rm[1], rm[0]};
                op_ld_acc_reg:      rm[0] = rm[s];
                op_ld_accpair_pair: {rm[1], rm[0]} = {rm[p+1], rm[p]};
                op_st_reg_acc:      if (s != 3'h0) rm[s] = rm[0];
                op_st_pair_accpair:
                    if (s != 3'h0) {rm[p+1], rm[p]} = {rm[1], rm[0]};
                op_sw_acc_ind, op_sw_acc_dir: begin
                    t[3:0] = mm[a];
                    mm[a] = rm[0];
                    rm[0] = t[3:0];
                end
                op_sw_accpair_ind, op_sw_accpair_dir: begin
                    t = {mm[e1], mm[e0]};
                    {mm[e1], mm[e0]} = {rm[1], rm[0]};
                    {rm[1], rm[0]} = t;
                end
                op_sw_acc_reg: if (s != 3'h0) begin
                    t[3:0] = rm[s];
                    rm[s] = rm[0];
                    rm[0] = t[3:0];
                end
                op_sw_accpair_pair: begin
                    t = {rm[p+1], rm[p]};
                    {rm[p+1], rm[p]} = {rm[1], rm[0]};
                    {rm[1], rm[0]} = t;
                end
                default: ;
            endcase
            run_m = str_none;
            if (op inside {op_ld_acc_imm, op_ld_accpair_imm}) run_m = str_acc;
            if (op == op_ld_dpp_imm) run_m = str_ptr;
            if (op inside {op_ld_acc_ind, op_sw_acc_ind} && s == 3'h1) begin
                rm[2] = rm[2] + 4'h1;
                sk_m = (rm[2] == 4'h0);
            end
            if (op inside {op_ld_acc_ind, op_sw_acc_ind} && s == 3'h2) begin
                rm[2] = rm[2] - 4'h1;
                sk_m = (rm[2] == 4'hf);
            end
        end
        eq.push_back('{ax: {rm[0], rm[1]}, p: {rm[3], rm[2]}, f: {sk_m, sq}});
    endtask : model

    task automatic issue(input op_type op, input logic [2:0] s,
                         input logic [7:0] im);
        @(posedge core_clk_i);
        instr_valid_i <= 1'b1;
        op_i <= op;
        sel_i <= s;
        imm_i <= im;
        model(op, s, im);
    endtask : issue

    task automatic idle();
        @(posedge core_clk_i);
        instr_valid_i <= 1'b0;
    endtask : idle

    task automatic peek(input logic use_mem, input string name);
        for (int i = 0; i < 256; i++) begin
            @(posedge core_clk_i);
            instr_valid_i <= 1'b0;
            peek_on <= 1'b1;
            dbg_addr_i <= 8'(i);
            reg_sel_i <= 4'(i);
            pq.push_back({use_mem, mm[i], rm[i%16]});
        end
        @(posedge core_clk_i);
        peek_on <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        $display("test %s done", name);
    endtask : peek

    initial begin
        core_clk_i = 1'b0;
        reset_i = 1'b1;
        instr_valid_i = 1'b0;
        op_i = op_nop;
        sel_i = 3'h0;
        imm_i = 8'h00;
        dbg_addr_i = 8'h00;
        reg_sel_i = 4'h0;
        peek_on = 1'b0;
        miscompares = 0;
        checked = 0;
        cycles = 0;
        rnd = 16'h32c2;
        sk_m = 1'b0;
        run_m = str_none;
        rm = '{default: 4'h0};
        op_k = '{op_ld_reg_imm, op_ld_pair_imm, op_ld_acc_reg,
                 op_ld_accpair_pair, op_st_reg_acc, op_st_pair_accpair,
                 op_sw_acc_reg, op_sw_accpair_pair, op_ld_acc_ind,
                 op_sw_acc_ind};
        repeat (12) @(posedge core_clk_i);
        reset_i <= 1'b0;
        peek(1'b0, "reset");
        // Memory has no reset, so every location is written before use.
        for (int i = 0; i < 256; i++) begin
            issue(op_ld_acc_imm, 3'h0, 8'(i * 7));
            issue(op_st_acc_dir, 3'h0, 8'(i));
        end
        peek(1'b1, "fill");
        issue(op_ld_dpp_imm, 3'h0, 8'h3f);
        issue(op_ld_acc_ind, 3'h1, 8'h00);
        issue(op_ld_acc_imm, 3'h0, 8'h05);
        issue(op_ld_dpp_imm, 3'h0, 8'h30);
        issue(op_sw_acc_ind, 3'h2, 8'h00);
        issue(op_st_acc_dir, 3'h0, 8'h11);
        issue(op_ld_acc_imm, 3'h0, 8'h0a);
        issue(op_ld_accpair_imm, 3'h0, 8'hc3);
        issue(op_ld_acc_imm, 3'h0, 8'h0b);
        idle();
        issue(op_ld_acc_imm, 3'h0, 8'h01);
        issue(op_ld_dpp_imm, 3'h0, 8'h47);
        issue(op_ld_dpp_imm, 3'h0, 8'h12);
        issue(op_ld_accpair_imm, 3'h0, 8'h5e);
        issue(op_ld_accpair_imm, 3'h0, 8'h6d);
        issue(op_ld_acc_imm, 3'h0, 8'h02);
        issue(op_ld_dpp_imm, 3'h0, 8'h47);
        issue(op_ld_accpair_ind, 3'h0, 8'h00);
        issue(op_sw_accpair_ind, 3'h0, 8'h00);
        issue(op_st_accpair_ind, 3'h0, 8'h00);
        issue(op_ld_accpair_dir, 3'h0, 8'h46);
        issue(op_sw_accpair_dir, 3'h0, 8'h92);
        issue(op_st_accpair_dir, 3'h0, 8'hfe);
        issue(op_sw_acc_dir, 3'h0, 8'hff);
        issue(op_ld_acc_dir, 3'h0, 8'hff);
        peek(1'b1, "directed");
        for (int s = 0; s < 8; s++) begin
            for (int k = 0; k < 10; k++) begin
                rnd = lfsr_next(rnd);
                issue(op_k[k], 3'(s), rnd[7:0]);
            end
        end
        peek(1'b1, "operands");
        for (int n = 0; n < 3000; n++) begin
            rnd = lfsr_next(rnd);
            if (rnd[15:13] == 3'h0) begin
                idle();
            end else begin
                ro = op_type'(5'(rnd % 16'd24));
                if (ro inside {op_ld_accpair_dir, op_st_accpair_dir,
                               op_sw_accpair_dir})
                    rnd[0] = 1'b0;
                issue(ro, rnd[10:8], rnd[7:0]);
            end
        end
        peek(1'b1, "random");
        issue(op_ld_acc_imm, 3'h0, 8'h03);
        idle();
        @(posedge core_clk_i);
        reset_i <= 1'b1;
        rm = '{default: 4'h0};
        sk_m = 1'b0;
        run_m = str_none;
        repeat (2) @(posedge core_clk_i);
        reset_i <= 1'b0;
        issue(op_ld_acc_imm, 3'h0, 8'h09);
        peek(1'b1, "second reset");
        end_of_test();
    end

endmodule : tb
